// file: hw/szm_pkg.sv
// Package: constants, types and rate table of the eight-line serial multiplexer
package szm_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int SZM_LINES         = 8;
  localparam int SZM_CLK_PERIOD_NS = 8;
  localparam int SZM_CLK_HZ        = 1_000_000_000 / SZM_CLK_PERIOD_NS;
  localparam int SZM_OSC_KHZ       = 5068;
  localparam int SZM_SCAN_PHASES   = 4;
  localparam int SZM_SILO_DEPTH    = 64;
  localparam int SZM_ALARM_COUNT   = 16;
  localparam int SZM_TIMER_W       = 22;
  localparam int SZM_SYNC_W        = 42;

  // ****************************************************************
  // Register word index (address bits 2:1) and field positions
  // ****************************************************************
  localparam logic [1:0] SZM_REG_CSR  = 2'h0;
  localparam logic [1:0] SZM_REG_RBUF = 2'h1;
  localparam logic [1:0] SZM_REG_TCR  = 2'h2;
  localparam logic [1:0] SZM_REG_MSR  = 2'h3;
  localparam int SZM_CSR_MAINT = 3;
  localparam int SZM_CSR_CLR   = 4;
  localparam int SZM_CSR_MSE   = 5;
  localparam int SZM_CSR_RIE   = 6;
  localparam int SZM_CSR_SAE   = 12;
  localparam int SZM_CSR_TIE   = 14;
  localparam int SZM_LPR_LINE  = 0;
  localparam int SZM_LPR_FLD   = 3;
  localparam logic [2:0]  SZM_IRQ_LEVEL = 3'h5;
  localparam logic [15:0] SZM_ZERO16    = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       ovrn;
    logic       ferr;
    logic       perr;
    logic [2:0] line;
    logic [7:0] data;
  } szm_char_s;

  typedef struct packed {
    logic       rx_en;
    logic [3:0] speed;
    logic       odd;
    logic       pen;
    logic       stop2;
    logic [1:0] len;
  } szm_lpr_s;

  typedef enum logic [1:0] {
    SZM_RX_IDLE  = 2'b00,
    SZM_RX_START = 2'b01,
    SZM_RX_DATA  = 2'b10
  } szm_rx_e;

  // Clock cycles in half a bit time for a speed code (rates in tenths of baud)
  function automatic int szm_half_bit(input int clk_hz, input logic [3:0] sp);
    int r10;
    case (sp)
      4'h0:    r10 = 500;
      4'h1:    r10 = 750;
      4'h2:    r10 = 1100;
      4'h3:    r10 = 1345;
      4'h4:    r10 = 1500;
      4'h5:    r10 = 3000;
      4'h6:    r10 = 6000;
      4'h7:    r10 = 12000;
      4'h8:    r10 = 18000;
      4'h9:    r10 = 20000;
      4'hA:    r10 = 24000;
      4'hB:    r10 = 36000;
      4'hC:    r10 = 48000;
      4'hD:    r10 = 72000;
      4'hE:    r10 = 96000;
      default: r10 = 192000;
    endcase
    return int'(longint'(clk_hz) * 5 / r10);
  endfunction

endpackage

// file: hw/szm_mux.sv
`timescale 1ns/1ns
// Eight-line asynchronous serial multiplexer with shared receive silo

// Contract
// RULE1: Character available flag is raised while a character sits at the silo output.
// RULE2: Fill alarm fires once sixteen characters entered the silo since arming.
// RULE3: A silo read re-arms the fill alarm for sixteen more entries.
// RULE4: With the alarm interrupt enabled, the per-character receive interrupt is suppressed.
// RULE5: Transmit ready rises when the scanner finds a line able to take a character.
// RULE6: Modem input changes never cause an interrupt; software polls them.
// RULE7: One start bit and one, one-and-a-half (five-bit only) or two stop bits.
// RULE8: Data length of five to eight bits per line, parity excluded.
// RULE9: No, odd or even parity; generated on transmit, checked on receive.
// RULE10: Data bits travel least significant bit first both ways.
// RULE11: Receiver tolerates edges displaced up to forty percent of a bit.
// RULE12: Receiver tolerates sender rate error of 3.8 percent at 2000, else 4.
// RULE13: Transmit rate error at most 2.2 percent at 2000, below 2 elsewhere.
// RULE14: A scanner visits lines in turn, moving receive and transmit data.
// RULE15: Received characters of all lines share one 64-entry first-in first-out silo.
// RULE16: Scanner timing comes from a 5.068 MHz oscillator through four phases.
// RULE17: Four device words present six 16-bit registers, two split read/write.
// RULE18: The host uses word accesses only on word-restricted registers.
// RULE19: Register strobes occur only when the address matches the base address.
// RULE20: Base address switches start at address bit 3; closed means one.
// RULE21: Vector switch positions 2 to 7 give vector bits 3 up; open means one.
// RULE22: Interrupt level is 5 by default, changed only by a plug.
// RULE23: Eight independent full-duplex serial lines.
// RULE24: Writes leave read-only bits alone; write-only and unused bits read zero.
// RULE25: Receiver detects the start edge and samples each bit at its centre.
module szm_mux
  import szm_pkg::*;
#(
  parameter int         CLK_HZ     = SZM_CLK_HZ,
  parameter int         SILO_DEPTH = SZM_SILO_DEPTH,
  parameter logic [2:0] IRQ_LEVEL  = SZM_IRQ_LEVEL
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [12:0] ADDR_I,
  input  wire logic [15:0] WR_DATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RD_DATA_O,
  input  wire logic [9:0]  SW_ADDR_I,
  input  wire logic [7:0]  SW_VEC_I,
  input  wire logic [7:0]  RXD_I,
  output logic      [7:0]  TXD_O,
  output logic      [7:0]  DTR_O,
  input  wire logic [7:0]  CARRIER_I,
  input  wire logic [7:0]  RING_I,
  output logic             RX_IRQ_O,
  output logic             TX_IRQ_O,
  output logic      [8:0]  IRQ_VECTOR_O,
  output logic      [2:0]  IRQ_LEVEL_O
);

  localparam int AW       = $clog2(SILO_DEPTH);
  localparam int SCAN_DIV = CLK_HZ / (SZM_OSC_KHZ * 1000 / SZM_SCAN_PHASES);
  localparam int TW       = SZM_TIMER_W;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [SZM_SYNC_W-1:0] meta_reg;
  logic [SZM_SYNC_W-1:0] sync_reg;
  logic [9:0]            sw_addr;
  logic [7:0]            sw_vec;
  logic [7:0]            rxd_s;
  logic [7:0]            carrier_s;
  logic [7:0]            ring_s;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= {SW_ADDR_I, SW_VEC_I, RXD_I, CARRIER_I, RING_I};
      sync_reg <= meta_reg;
    end
  end
  assign {sw_addr, sw_vec, rxd_s, carrier_s, ring_s} = sync_reg;

  // ****************************************************************
  // Address decode and registers
  // ****************************************************************
  logic            hit;
  logic [1:0]      sel;
  logic            wr_csr;
  logic            wr_lpr;
  logic            wr_tcr;
  logic            wr_tdr;
  logic            rbuf_rd;
  logic            maint_reg;
  logic            clr_reg;
  logic            mse_reg;
  logic            rie_reg;
  logic            sae_reg;
  logic            tie_reg;
  logic [7:0]      line_en_reg;
  logic [7:0]      dtr_reg;
  logic [7:0]      brk_reg;
  szm_lpr_s        lpr_reg [SZM_LINES];

  assign hit     = (ADDR_I[12:3] == sw_addr);      // see RULE19 see RULE20
  assign sel     = ADDR_I[2:1];
  assign wr_csr  = WR_I && hit && (sel == SZM_REG_CSR);
  assign wr_lpr  = WR_I && hit && (sel == SZM_REG_RBUF);  // see RULE17
  assign wr_tcr  = WR_I && hit && (sel == SZM_REG_TCR);
  assign wr_tdr  = WR_I && hit && (sel == SZM_REG_MSR);
  assign rbuf_rd = RD_I && hit && (sel == SZM_REG_RBUF);

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      {maint_reg, clr_reg, mse_reg, rie_reg, sae_reg, tie_reg} <= '0;
      line_en_reg <= '0;
      dtr_reg     <= '0;
      brk_reg     <= '0;
      for (int k = 0; k < SZM_LINES; k++) lpr_reg[k] <= '0;
    end else begin
      clr_reg <= wr_csr && WR_DATA_I[SZM_CSR_CLR];
      if (wr_csr) begin
        maint_reg <= WR_DATA_I[SZM_CSR_MAINT];
        mse_reg   <= WR_DATA_I[SZM_CSR_MSE];
        rie_reg   <= WR_DATA_I[SZM_CSR_RIE];
        sae_reg   <= WR_DATA_I[SZM_CSR_SAE];
        tie_reg   <= WR_DATA_I[SZM_CSR_TIE];
      end
      if (wr_lpr) begin
        lpr_reg[WR_DATA_I[SZM_LPR_LINE +: 3]] <= szm_lpr_s'(WR_DATA_I[SZM_LPR_FLD +: 10]);
      end
      if (wr_tcr) begin
        {dtr_reg, line_en_reg} <= WR_DATA_I;
      end
      if (wr_tdr) begin
        brk_reg <= WR_DATA_I[15:8];
      end
    end
  end

  // ****************************************************************
  // Receive silo and fill alarm
  // ****************************************************************
  szm_char_s     silo_mem [SILO_DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   silo_cnt;
  logic [4:0]    alarm_cnt;
  logic          silo_fill_alarm;
  logic          rx_char_available;
  logic          push;
  logic          pop;
  szm_char_s     push_char;

  assign rx_char_available = (silo_cnt != '0);    // see RULE1
  assign pop               = rbuf_rd && rx_char_available;

  always_ff @(posedge SYS_CLK_I) begin
    if (push) begin
      silo_mem[wr_ptr] <= push_char;               // see RULE15
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      silo_cnt <= '0;
    end else if (clr_reg) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      silo_cnt <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) silo_cnt <= silo_cnt + 1'b1;
      else if (pop && !push) silo_cnt <= silo_cnt - 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      alarm_cnt       <= '0;
      silo_fill_alarm <= 1'b0;
    end else if (clr_reg) begin
      alarm_cnt       <= '0;
      silo_fill_alarm <= 1'b0;
    end else if (rbuf_rd) begin
      alarm_cnt       <= {4'h0, push};             // see RULE3
      silo_fill_alarm <= 1'b0;
    end else if (push && (alarm_cnt != 5'(SZM_ALARM_COUNT))) begin
      alarm_cnt <= alarm_cnt + 1'b1;
      if (alarm_cnt == 5'(SZM_ALARM_COUNT - 1)) begin
        silo_fill_alarm <= 1'b1;                   // see RULE2
      end
    end
  end

  // ****************************************************************
  // Scanner
  // ****************************************************************
  logic [7:0]  osc_cnt;
  logic [1:0]  phase;
  logic        step;
  logic [2:0]  scan_line;
  logic        tx_line_ready;
  logic [2:0]  tx_line;
  logic [7:0]  hold_full;
  logic [7:0]  tx_full;
  logic [7:0]  tx_busy_v;
  logic [7:0]  take;
  logic [7:0]  load;
  szm_char_s   hold_q [SZM_LINES];

  assign step      = (osc_cnt == 8'(SCAN_DIV - 1)) && (phase == 2'h3);  // see RULE16
  assign push      = step && mse_reg && hold_full[scan_line] && (silo_cnt != SILO_DEPTH);
  assign push_char = hold_q[scan_line];
  assign take      = push ? (8'h01 << scan_line) : 8'h00;
  assign load      = (wr_tdr && tx_line_ready) ? (8'h01 << tx_line) : 8'h00;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      osc_cnt <= '0;
      phase   <= '0;
    end else if (osc_cnt == 8'(SCAN_DIV - 1)) begin
      osc_cnt <= '0;
      phase   <= phase + 1'b1;
    end else begin
      osc_cnt <= osc_cnt + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      scan_line     <= '0;
      tx_line_ready <= 1'b0;
      tx_line       <= '0;
    end else if (clr_reg || !mse_reg) begin
      tx_line_ready <= 1'b0;
    end else if (wr_tdr && tx_line_ready) begin
      tx_line_ready <= 1'b0;
    end else if (step && !tx_line_ready) begin
      if (line_en_reg[scan_line] && !tx_full[scan_line]) begin
        tx_line_ready <= 1'b1;                     // see RULE5
        tx_line       <= scan_line;
      end else begin
        scan_line <= scan_line + 1'b1;             // see RULE14
      end
    end
  end

  // ****************************************************************
  // Line transmitters and receivers
  // ****************************************************************
  for (genvar i = 0; i < SZM_LINES; i++) begin : g_line  // see RULE23
    szm_lpr_s      lp;
    logic [TW-1:0] half;
    logic [3:0]    nbits;
    logic [4:0]    hlast;
    logic [11:0]   frame;
    logic          tx_par;
    logic [7:0]    tx_buf;
    logic          full_r;
    logic          busy_r;
    logic [11:0]   frame_r;
    logic [4:0]    hidx_r;
    logic [4:0]    hlast_r;
    logic [TW-1:0] ttim_r;
    logic          txd_r;
    logic          ri;
    szm_rx_e       rx_st;
    logic [TW-1:0] rtim_r;
    logic [3:0]    ridx_r;
    logic [7:0]    rdat_r;
    logic          rpar_r;
    logic          hfull_r;
    szm_char_s     hold_r;

    assign lp     = lpr_reg[i];
    assign half   = TW'(szm_half_bit(CLK_HZ, lp.speed));     // see RULE12 see RULE13
    assign nbits  = {2'h0, lp.len} + 4'h5;                   // see RULE8
    assign tx_par = ^tx_buf ^ lp.odd;                        // see RULE9
    assign hlast  = 5'({nbits, 1'b0}) + 5'({lp.pen, 1'b0}) + 5'h2
                    + (lp.stop2 ? ((lp.len == 2'h0) ? 5'h3 : 5'h4) : 5'h2);  // see RULE7

    always_comb begin
      frame    = '1;
      frame[0] = 1'b0;
      for (int b = 0; b < 8; b++) begin
        if (b < nbits) frame[b + 1] = tx_buf[b];             // see RULE10
      end
      if (lp.pen) frame[nbits + 1] = tx_par;
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        tx_buf <= '0;
        full_r <= 1'b0;
      end else if (clr_reg) begin
        full_r <= 1'b0;
      end else if (load[i]) begin
        tx_buf <= WR_DATA_I[7:0] & ~(8'hFF << nbits);
        full_r <= 1'b1;
      end else if (!busy_r) begin
        full_r <= 1'b0;
      end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        busy_r  <= 1'b0;
        frame_r <= '1;
        hidx_r  <= '0;
        hlast_r <= '0;
        ttim_r  <= '0;
        txd_r   <= 1'b1;
      end else begin
        txd_r <= !brk_reg[i] && (!busy_r || frame_r[hidx_r[4:1]]);
        if (clr_reg) begin
          busy_r <= 1'b0;
        end else if (!busy_r) begin
          if (full_r) begin
            busy_r  <= 1'b1;
            frame_r <= frame;
            hidx_r  <= '0;
            hlast_r <= hlast;
            ttim_r  <= half - 1'b1;
          end
        end else if (ttim_r == '0) begin
          ttim_r <= half - 1'b1;
          hidx_r <= hidx_r + 1'b1;
          if (hidx_r + 1'b1 == hlast_r) busy_r <= 1'b0;
        end else begin
          ttim_r <= ttim_r - 1'b1;
        end
      end
    end

    assign ri = maint_reg ? txd_r : rxd_s[i];

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
        rx_st   <= SZM_RX_IDLE;
        rtim_r  <= '0;
        ridx_r  <= '0;
        rdat_r  <= '0;
        rpar_r  <= 1'b0;
        hfull_r <= 1'b0;
        hold_r  <= '0;
      end else if (clr_reg) begin
        rx_st   <= SZM_RX_IDLE;
        hfull_r <= 1'b0;
      end else begin
        if (take[i]) hfull_r <= 1'b0;
        case (rx_st)
          SZM_RX_IDLE: begin
            if (!ri && lp.rx_en) begin
              rx_st  <= SZM_RX_START;              // see RULE25
              rtim_r <= half - 1'b1;
            end
          end
          SZM_RX_START: begin
            if (rtim_r != '0) begin
              rtim_r <= rtim_r - 1'b1;
            end else if (ri) begin
              rx_st <= SZM_RX_IDLE;
            end else begin
              rx_st  <= SZM_RX_DATA;
              rtim_r <= {half[TW-2:0], 1'b0} - 1'b1;  // see RULE11
              ridx_r <= '0;
              rdat_r <= '0;
            end
          end
          SZM_RX_DATA: begin
            if (rtim_r != '0) begin
              rtim_r <= rtim_r - 1'b1;
            end else begin
              rtim_r <= {half[TW-2:0], 1'b0} - 1'b1;
              ridx_r <= ridx_r + 1'b1;
              if (ridx_r < nbits) begin
                rdat_r[ridx_r[2:0]] <= ri;          // see RULE10
              end else if (ridx_r == nbits && lp.pen) begin
                rpar_r <= ri;
              end else begin
                rx_st        <= SZM_RX_IDLE;
                hfull_r      <= 1'b1;
                hold_r.ovrn  <= hfull_r && !take[i];
                hold_r.ferr  <= !ri;
                hold_r.perr  <= lp.pen && (rpar_r != (^rdat_r ^ lp.odd));  // see RULE9
                hold_r.line  <= 3'(i);
                hold_r.data  <= rdat_r;
              end
            end
          end
          default: rx_st <= SZM_RX_IDLE;
        endcase
      end
    end

    assign hold_full[i] = hfull_r;
    assign hold_q[i]    = hold_r;
    assign tx_full[i]   = full_r || busy_r;
    assign tx_busy_v[i] = busy_r;
    assign TXD_O[i]     = txd_r;
  end

  // ****************************************************************
  // Read data, interrupts and straps
  // ****************************************************************
  logic [15:0] rd_next;
  logic [15:0] rd_data_reg;
  szm_char_s   head;

  assign head = silo_mem[rd_ptr];

  always_comb begin
    case (sel)                                     // see RULE17 see RULE24
      SZM_REG_CSR:  rd_next = {tx_line_ready, tie_reg, silo_fill_alarm, sae_reg, 1'b0,
                               tx_line, rx_char_available, rie_reg, mse_reg, clr_reg,
                               maint_reg, 3'h0};
      SZM_REG_RBUF: rd_next = rx_char_available ? {1'b1, head.ovrn, head.ferr, head.perr,
                               1'b0, head.line, head.data} : SZM_ZERO16;
      SZM_REG_TCR:  rd_next = {dtr_reg, line_en_reg};
      SZM_REG_MSR:  rd_next = {carrier_s, ring_s};
      default:      rd_next = SZM_ZERO16;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= (RD_I && hit) ? rd_next : SZM_ZERO16;
    end
  end

  assign RD_DATA_O    = rd_data_reg;
  assign DTR_O        = dtr_reg;
  // Modem inputs feed only the status word, no interrupt path (see RULE6)
  assign RX_IRQ_O     = rie_reg && (sae_reg ? silo_fill_alarm : rx_char_available);  // see RULE4
  assign TX_IRQ_O     = tie_reg && tx_line_ready;
  assign IRQ_VECTOR_O = {sw_vec[6:1], 3'h0};      // see RULE21
  assign IRQ_LEVEL_O  = IRQ_LEVEL;                 // see RULE22

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_tx_go;
    !tx_busy_v[0] ##1 tx_busy_v[0];
  endsequence

  a_rx_char_available_rise: assert property (push && !pop && !clr_reg |=> rx_char_available)  // see RULE1
    else $error("character pushed but none available");
  a_alarm_fire: assert property (push && !rbuf_rd && !clr_reg
    && alarm_cnt == 5'(SZM_ALARM_COUNT - 1) |=> silo_fill_alarm)  // see RULE2
    else $error("alarm missing after sixteenth entry");
  a_alarm_rearm: assert property (rbuf_rd |=> !silo_fill_alarm && alarm_cnt <= 5'h1)  // see RULE3
    else $error("silo read did not re-arm alarm");
  a_irq_masked: assert property (sae_reg && !silo_fill_alarm |-> !RX_IRQ_O)  // see RULE4
    else $error("per-character interrupt while alarm mode on");
  a_tx_line_ready_line: assert property ($rose(tx_line_ready) |-> line_en_reg[tx_line]
    && !tx_full[tx_line])  // see RULE5
    else $error("ready raised for a line that cannot send");
  a_start_bit: assert property (s_tx_go |-> ##1 (!TXD_O[0] || $past(brk_reg[0])))  // see RULE7
    else $error("no start bit after transmit began");
  a_scan_walk: assert property (step && mse_reg && !tx_line_ready && !clr_reg
    && !(line_en_reg[scan_line] && !tx_full[scan_line]) |=> scan_line == $past(scan_line) + 3'h1)  // see RULE14
    else $error("scanner skipped or stuck");
  a_silo_bound: assert property (silo_cnt <= SILO_DEPTH)  // see RULE15
    else $error("silo count above depth");
  a_miss_zero: assert property (RD_I && !hit |=> RD_DATA_O == SZM_ZERO16)  // see RULE19
    else $error("read answered at a foreign address");

endmodule

// file: bench/szm_term.sv
`timescale 1ns/1ns
// Serial terminal model: frames characters onto receive lines and reads transmit lines
module szm_term #(
  parameter int BIT = 104
) (
  input  wire logic       clk_i,
  input  wire logic [7:0] txd_i,
  output logic      [7:0] rxd_o
);
  initial rxd_o = 8'hFF;

  // Start 0, data LSB first, optional parity, then mark stop bits
  function automatic logic fbit(input logic [7:0] c, input int t, input int w,
                                input int par, input bit bad);
    logic [7:0] m;
    m = 8'((1 << w) - 1);
    if (t == 0) return 1'b0;
    if (t <= w) return c[t-1];
    if (t == w + 1 && par != 0) return ^(c & m) ^ (par == 2) ^ bad;
    return 1'b1;
  endfunction

  // One frame on every line in mask, each line with its own byte of c
  task automatic send(input logic [7:0] mask, input logic [63:0] c, input int n,
                      input int par, input bit s2, input bit bad, input int sk);
    int         nb;
    logic [7:0] f;
    nb = n + 7 + (par != 0) + s2;
    for (int t = 0; t < nb; t++) begin
      for (int l = 0; l < 8; l++) f[l] = !mask[l] || fbit(c[8*l+:8], t, n + 5, par, bad);
      @(posedge clk_i);
      rxd_o <= f;
      repeat (BIT - 1 + sk) @(posedge clk_i);
    end
  endtask

  // Waits for a start bit, then samples each data bit at its centre
  task automatic recv(input int l, input int n, output logic [7:0] d);
    d = 8'h00;
    for (int w = 0; w < 3000 && txd_i[l] !== 1'b0; w++) @(posedge clk_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < n + 5; i++) begin
      repeat (BIT) @(posedge clk_i);
      d[i] = txd_i[l];
    end
  endtask
endmodule

// file: bench/szm_mux_test.sv
`timescale 1ns/1ns
// Self-checking bench of the eight-line serial multiplexer
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module szm_mux_test;
  import szm_pkg::*;
  localparam int HZ  = 2_000_000;
  localparam int BIT = 2 * (HZ * 5 / 192000);
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rx_irq, tx_irq;
  logic [12:0] addr = 13'h0000;
  logic [15:0] wdat = 16'h0000, rdat, v;
  logic [9:0]  swa;
  logic [7:0]  swv, car = 8'h00, ring = 8'h00, rxd, txd, dtr, d, d2;
  logic [8:0]  vec;
  logic [2:0]  lvl;
  logic [63:0] chars;
  int          seed = 25953, error_cnt = 0, checked = 0, len, par, ln;
  bit          s2;

  szm_mux #(.CLK_HZ(HZ)) u_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WR_DATA_I(wdat), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdat), .SW_ADDR_I(swa),
    .SW_VEC_I(swv), .RXD_I(rxd), .TXD_O(txd), .DTR_O(dtr), .CARRIER_I(car),
    .RING_I(ring), .RX_IRQ_O(rx_irq), .TX_IRQ_O(tx_irq), .IRQ_VECTOR_O(vec),
    .IRQ_LEVEL_O(lvl));
  szm_term #(.BIT(BIT)) u_term (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr_reg(input logic [1:0] i, input logic [15:0] x);
    @(posedge clk);
    addr <= {swa, i, 1'b0};
    wdat <= x;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask

  task automatic rd_at(input logic [12:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdat;
  endtask

  function automatic logic [7:0] msk(input logic [7:0] c, input int n);
    return c & 8'((1 << (n + 5)) - 1);
  endfunction

  function automatic logic [15:0] lpr(input int l, input int n, input int p, input bit s);
    return 16'h1F00 | 16'(((p == 2) << 7) | ((p != 0) << 6) | (s << 5) | (n << 3) | l);
  endfunction

  initial begin
    #800000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    swa = 10'($random(seed));
    swv = 8'($random(seed));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("txd idle", 8'hFF, txd)
    `CHK("level", 3'h5, lvl)
    `CHK("vector", {swv[6:1], 3'h0}, vec)
    rd_at({~swa, 3'h0});
    `CHK("unmapped", 16'h0000, v)
    wr_reg(SZM_REG_CSR, 16'hFFE0);
    rd_at({swa, SZM_REG_CSR, 1'b0});
    `CHK("csr", 16'h5060, v)
    @(posedge clk);
    car  <= 8'($random(seed));
    ring <= 8'($random(seed));
    repeat (6) @(posedge clk);
    rd_at({swa, SZM_REG_MSR, 1'b0});
    `CHK("msr", {car, ring}, v)
    `CHK("modem irq", 2'b00, {rx_irq, tx_irq})
    for (int k = 0; k < 13; k++) begin
      len = k % 4;
      par = (k / 4) % 3 + (k == 12);
      s2  = $random(seed);
      ln  = {$random(seed)} % 8;
      d   = 8'($random(seed));
      wr_reg(SZM_REG_TCR, 16'h0000);
      wr_reg(SZM_REG_CSR, 16'h4070);
      wr_reg(SZM_REG_RBUF, lpr(ln, len, par, s2));
      chars = 64'(d) << (8 * ln);
      u_term.send(8'h01 << ln, chars, len, par, s2, k == 12, 4 * (k % 3) - 4);
      repeat (100) @(posedge clk);
      #1;
      `CHK("rx irq", 1'b1, rx_irq)
      rd_at({swa, SZM_REG_RBUF, 1'b0});
      `CHK("rbuf", {3'b100, k == 12, 1'b0, 3'(ln), msk(d, len)}, v)
      if (k < 12) begin
        wr_reg(SZM_REG_TCR, {d, 8'h01 << ln});
        for (int w = 0; w < 500 && tx_irq !== 1'b1; w++) @(posedge clk);
        rd_at({swa, SZM_REG_CSR, 1'b0});
        `CHK("tx ready", {1'b1, 3'(ln)}, {v[15], v[10:8]})
        `CHK("dtr", d, dtr)
        wr_reg(SZM_REG_MSR, {8'h00, ~d});
        u_term.recv(ln, len, d2);
        `CHK("txd", msk(~d, len), d2)
      end
    end
    wr_reg(SZM_REG_TCR, 16'h0000);
    wr_reg(SZM_REG_CSR, 16'h1070);
    for (int l = 0; l < 8; l++) wr_reg(SZM_REG_RBUF, lpr(l, 3, 0, 1'b0));
    chars = {$random(seed), $random(seed)};
    for (int r = 0; r < 2; r++) begin
      u_term.send(8'hFF, chars, 3, 0, 1'b0, 1'b0, 0);
      repeat (100) @(posedge clk);
      rd_at({swa, SZM_REG_CSR, 1'b0});
      `CHK("alarm", {r == 1, 1'b1, r == 1}, {v[13], v[7], rx_irq})
    end
    for (int i = 0; i < 17; i++) begin
      rd_at({swa, SZM_REG_RBUF, 1'b0});
      `CHK("silo valid", i < 16, v[15])
      if (i == 0) begin
        rd_at({swa, SZM_REG_CSR, 1'b0});
        `CHK("rearm", 1'b0, v[13])
      end
    end
    tally_and_finish();
  end
endmodule
